// [hw/csd_sequence_model.sv]
/*
  Behavioural model of four execution defects of a 20-bit CPU core.
  Each retired instruction arrives as a class with its address; the
  model reports fetch targets, saved return addresses, PC write
  corruption and handler operand width.
  Assumes a decoder classifies instructions and one core clock.
*/
// Contract
// - Call through SP starts at SP+2
// - Nested save after lpm/return saves PC+2
// - Following return skipped, PC corrupted
// - PC write after extended write-back misexecutes
// - Only indirect/autoinc/index-zero PC destination forms
// - NMI handler first instruction runs 20-bit
module csd_sequence_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instValid,
  input wire logic [3:0] instClass,
  input wire logic [19:0] instAddr,
  input wire logic [19:0] instTarget,
  input wire logic [19:0] stackPtr,
  input wire logic nestEnable,
  input wire logic nestedIrq,
  input wire logic nmiPending,
  input wire logic handlerFirst,
  output logic [19:0] fetchAddr,
  output logic fetchValid,
  output logic [19:0] savedReturn,
  output logic saveValid,
  output logic returnSkipped,
  output logic pcCorrupt,
  output logic [1:0] handlerWidth
);

  csd_pkg::csd_state_t state, next_state;
  logic [19:0] next_fetchAddr, next_savedReturn;
  logic next_fetchValid, next_saveValid, next_returnSkipped, next_pcCorrupt;
  logic [1:0] next_handlerWidth;
  logic lpmInHandler, next_lpmInHandler;
  logic nmiArmed, setArm, clearArm;
  logic lastIndexed, next_lastIndexed;

  // Class check shared by several paths
  function automatic logic isClass(input logic [3:0] cls, input logic [3:0] want);
    isClass = (cls == want);
  endfunction

  // ****************************************************************
  // Arming of the handler width defect
  // ****************************************************************
  csd_arm_latch uArm (
    .clk(clk),
    .sys_rst(sys_rst),
    .setArm(setArm),
    .clearArm(clearArm),
    .armed(nmiArmed)
  );

  // ****************************************************************
  // Sequence watcher: only the directly following instruction counts
  // ****************************************************************
  always_comb
  begin
    next_state = csd_pkg::CSD_IDLE;
    next_lpmInHandler = lpmInHandler;
    next_fetchAddr = fetchAddr;
    next_fetchValid = 1'b0;
    next_savedReturn = savedReturn;
    next_saveValid = 1'b0;
    next_returnSkipped = 1'b0;
    next_pcCorrupt = 1'b0;
    next_handlerWidth = handlerWidth;
    setArm = 1'b0;
    clearArm = 1'b0;
    if (nestedIrq)
    begin
      // Context save; defective only right after lpm entry then return
      next_saveValid = 1'b1;
      if (lpmInHandler)
      begin
        next_savedReturn = instAddr + csd_pkg::WORD_STEP;
        next_returnSkipped = 1'b1;
      end
      else
        next_savedReturn = instAddr;
      next_lpmInHandler = 1'b0;
      next_state = state;
    end
    else if (handlerFirst)
    begin
      // Width of the handler's first instruction
      if (nmiArmed)
        next_handlerWidth = csd_pkg::WIDTH_20;
      else
        next_handlerWidth = csd_pkg::WIDTH_BYTE_WORD;
      clearArm = 1'b1;
    end
    else if (instValid)
    begin
      next_lpmInHandler = 1'b0;
      case (state)
        csd_pkg::CSD_AFTER_LPM:
        begin
          // Lpm entry directly followed by return in a nesting handler
          if (isClass(instClass, csd_pkg::CLS_RETURN) && nestEnable)
            next_lpmInHandler = 1'b1;
          // Only an indexed-source lpm entry may arm the width defect
          if (isClass(instClass, csd_pkg::CLS_X20_REG_REG) && nmiPending && lastIndexed)
            setArm = 1'b1;
        end
        csd_pkg::CSD_AFTER_XWB:
        begin
          if (isClass(instClass, csd_pkg::CLS_X_PC_INDIRECT))
            next_pcCorrupt = 1'b1;
        end
        default:
        begin
        end
      endcase
      // Classify this instruction to open the next window
      case (instClass)
        csd_pkg::CLS_CALL_SP:
        begin
          next_fetchAddr = stackPtr + csd_pkg::WORD_STEP;
          next_fetchValid = 1'b1;
        end
        csd_pkg::CLS_LPM_ENTRY:
          next_state = csd_pkg::CSD_AFTER_LPM;
        csd_pkg::CLS_LPM_INDEXED:
          next_state = csd_pkg::CSD_AFTER_LPM;
        csd_pkg::CLS_XWB_REG_MEM:
          next_state = csd_pkg::CSD_AFTER_XWB;
        csd_pkg::CLS_X_PC_INDIRECT:
        begin
          // Faulty write lands one bit off; normal write otherwise
          next_fetchAddr = (state == csd_pkg::CSD_AFTER_XWB) ?
            (instTarget ^ csd_pkg::PC_CORRUPT_XOR) : instTarget;
          next_fetchValid = 1'b1;
        end
        default:
          next_state = csd_pkg::CSD_IDLE;
      endcase
    end
    else
      next_state = state;
  end

  // Indexed-entry tracking; plain lpm entry must not arm
  always_comb
  begin
    next_lastIndexed = lastIndexed;
    if (instValid && !nestedIrq && !handlerFirst)
      next_lastIndexed = isClass(instClass, csd_pkg::CLS_LPM_INDEXED);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= csd_pkg::CSD_IDLE;
      lpmInHandler <= 1'b0;
      lastIndexed <= 1'b0;
      fetchAddr <= csd_pkg::PC_RESET;
      fetchValid <= 1'b0;
      savedReturn <= csd_pkg::PC_RESET;
      saveValid <= 1'b0;
      returnSkipped <= 1'b0;
      pcCorrupt <= 1'b0;
      handlerWidth <= csd_pkg::WIDTH_BYTE_WORD;
    end
    else
    begin
      state <= next_state;
      lpmInHandler <= next_lpmInHandler;
      lastIndexed <= next_lastIndexed;
      fetchAddr <= next_fetchAddr;
      fetchValid <= next_fetchValid;
      savedReturn <= next_savedReturn;
      saveValid <= next_saveValid;
      returnSkipped <= next_returnSkipped;
      pcCorrupt <= next_pcCorrupt;
      handlerWidth <= next_handlerWidth;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_call_sp;
    @(posedge clk) disable iff (sys_rst)
    instValid && !nestedIrq && !handlerFirst && instClass == csd_pkg::CLS_CALL_SP
      |=> fetchValid && fetchAddr == $past(stackPtr) + 20'h00002;
  endproperty
  a_call_sp: assert property (p_call_sp) else $error("call via SP not at SP+2");

  property p_nested_save;
    @(posedge clk) disable iff (sys_rst)
    nestedIrq && lpmInHandler |=> saveValid && savedReturn == $past(instAddr) + 20'h00002;
  endproperty
  a_nested_save: assert property (p_nested_save) else $error("nested save not PC+2");

  property p_skip;
    @(posedge clk) disable iff (sys_rst)
    nestedIrq |=> returnSkipped == $past(lpmInHandler);
  endproperty
  a_skip: assert property (p_skip) else $error("return skip flag wrong");

  property p_pc_corrupt;
    @(posedge clk) disable iff (sys_rst)
    instValid && !nestedIrq && !handlerFirst && state == csd_pkg::CSD_AFTER_XWB
      && instClass == csd_pkg::CLS_X_PC_INDIRECT |=> pcCorrupt;
  endproperty
  a_pc_corrupt: assert property (p_pc_corrupt) else $error("PC corruption missed");

  property p_pc_clean;
    @(posedge clk) disable iff (sys_rst)
    pcCorrupt |-> $past(state) == csd_pkg::CSD_AFTER_XWB;
  endproperty
  a_pc_clean: assert property (p_pc_clean) else $error("spurious PC corruption");

  property p_width;
    @(posedge clk) disable iff (sys_rst)
    handlerFirst && !nestedIrq |=> handlerWidth == ($past(nmiArmed) ? 2'h1 : 2'h0);
  endproperty
  a_width: assert property (p_width) else $error("handler width wrong");

  property p_plain_no_arm;
    @(posedge clk) disable iff (sys_rst)
    instValid && !nestedIrq && !handlerFirst && !lastIndexed && !nmiArmed |=> !nmiArmed;
  endproperty
  a_plain_no_arm: assert property (p_plain_no_arm) else $error("width defect armed without indexed entry");

  property p_nop_clears;
    @(posedge clk) disable iff (sys_rst)
    instValid && !nestedIrq && !handlerFirst && instClass == csd_pkg::CLS_NOP
      |=> state == csd_pkg::CSD_IDLE && !lpmInHandler;
  endproperty
  a_nop_clears: assert property (p_nop_clears) else $error("no-op did not clear");

  property p_normal_save;
    @(posedge clk) disable iff (sys_rst)
    nestedIrq && !lpmInHandler |=> savedReturn == $past(instAddr) && !returnSkipped;
  endproperty
  a_normal_save: assert property (p_normal_save) else $error("normal save wrong");

endmodule

// [shared/csd_pkg.sv]
/*
  Package for the CPU sequence defect model: instruction classes,
  fetch offsets, width codes and the handler state encoding.
  Assumes a decoder upstream classifies each retired instruction.
*/
package csd_pkg;

  // ****************************************************************
  // Instruction classes presented by the decoder
  // ****************************************************************
  localparam logic [3:0] CLS_OTHER = 4'h0;
  localparam logic [3:0] CLS_NOP = 4'h1;
  localparam logic [3:0] CLS_CALL_SP = 4'h2;
  localparam logic [3:0] CLS_LPM_ENTRY = 4'h3;
  localparam logic [3:0] CLS_RETURN = 4'h4;
  localparam logic [3:0] CLS_XWB_REG_MEM = 4'h5;
  localparam logic [3:0] CLS_X_PC_INDIRECT = 4'h6;
  localparam logic [3:0] CLS_LPM_INDEXED = 4'h7;
  localparam logic [3:0] CLS_X20_REG_REG = 4'h8;

  // ****************************************************************
  // Offsets and widths
  // ****************************************************************
  localparam logic [19:0] WORD_STEP = 20'h00002;
  localparam logic [19:0] PC_CORRUPT_XOR = 20'h00001;
  localparam logic [1:0] WIDTH_BYTE_WORD = 2'h0;
  localparam logic [1:0] WIDTH_20 = 2'h1;
  localparam logic [19:0] PC_RESET = 20'h00000;

  // One-hot states of the sequence watcher
  typedef enum logic [3:0] {
    CSD_IDLE = 4'h1,
    CSD_AFTER_LPM = 4'h2,
    CSD_AFTER_XWB = 4'h4,
    CSD_NMI_ARMED = 4'h8
  } csd_state_t;

endpackage

// [hw/csd_arm_latch.sv]
/*
  Holds the armed flag for the non-maskable handler width defect.
  Assumes one clock, asynchronous active-high reset.
*/
module csd_arm_latch (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic setArm,
  input wire logic clearArm,
  output logic armed
);

  logic next_armed;

  // ****************************************************************
  // Next value: set wins over clear so a fresh arming is not lost
  // ****************************************************************
  always_comb
  begin
    next_armed = armed;
    if (clearArm)
      next_armed = 1'b0;
    if (setArm)
      next_armed = 1'b1;
  end

  // Register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      armed <= 1'b0;
    else
      armed <= next_armed;
  end

endmodule

// [testbench/csd_stream_src.sv]
/*
  Far-side model: the retired-instruction stream and interrupt sources.
  Assumes the bench calls step once per cycle, always after a rising edge.
*/
module csd_stream_src (
  input wire logic clk,
  output logic instValid,
  output logic [3:0] instClass,
  output logic [19:0] instAddr,
  output logic [19:0] instTarget,
  output logic [19:0] stackPtr,
  output logic nestEnable,
  output logic nestedIrq,
  output logic nmiPending,
  output logic handlerFirst
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Stream driver
  // ****************************************************************
  // Quiet start so nothing is taken during reset
  initial
  begin
    {instValid, instClass, instAddr, instTarget, stackPtr} = '0;
    {nestEnable, nestedIrq, nmiPending, handlerFirst} = '0;
  end

  // One cycle of stream; a no-op class between a pair is the software fix
  task automatic step(input logic [3:0] c, input logic v, input logic [19:0] a,
                      input logic [19:0] t, input logic irq, input logic hf);
    @(posedge clk);
    #1;
    instValid = v;
    instClass = c;
    // An idle address must not look like a held one
    instAddr = (v | irq) ? a : ~instAddr;
    stackPtr = a;
    instTarget = t;
    nestedIrq = irq;
    handlerFirst = hf;
  endtask
endmodule

// [testbench/cpu_sequence_defect_model_bench.sv]
/*
  Self-checking bench for the CPU sequence defect model.
  Assumes the design answers at the taking edge, one cycle after the drive.
*/
module cpu_sequence_defect_model_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instValid, nestEnable, nestedIrq, nmiPending, handlerFirst;
  logic [3:0] instClass;
  logic [19:0] instAddr, instTarget, stackPtr, fetchAddr, savedReturn;
  logic fetchValid, saveValid, returnSkipped, pcCorrupt;
  logic [1:0] handlerWidth;
  int fail_count = 0;
  int tests_run = 0;

  // ****************************************************************
  // Clock, instances, checks
  // ****************************************************************
  always #50 clk = ~clk;
  csd_stream_src src (
    .clk(clk),
    .instValid(instValid),
    .instClass(instClass),
    .instAddr(instAddr),
    .instTarget(instTarget),
    .stackPtr(stackPtr),
    .nestEnable(nestEnable),
    .nestedIrq(nestedIrq),
    .nmiPending(nmiPending),
    .handlerFirst(handlerFirst)
  );
  csd_sequence_model uut (
    .clk(clk),
    .sys_rst(sys_rst),
    .instValid(instValid),
    .instClass(instClass),
    .instAddr(instAddr),
    .instTarget(instTarget),
    .stackPtr(stackPtr),
    .nestEnable(nestEnable),
    .nestedIrq(nestedIrq),
    .nmiPending(nmiPending),
    .handlerFirst(handlerFirst),
    .fetchAddr(fetchAddr),
    .fetchValid(fetchValid),
    .savedReturn(savedReturn),
    .saveValid(saveValid),
    .returnSkipped(returnSkipped),
    .pcCorrupt(pcCorrupt),
    .handlerWidth(handlerWidth)
  );

  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string what);
    chk({19'h0, got}, {19'h0, exp}, what);
  endtask

  // Idle cycle lets the answer of the previous edge land
  task automatic idle();
    src.step(csd_pkg::CLS_OTHER, 1'b0, 20'h0, 20'h0, 1'b0, 1'b0);
  endtask

  task automatic inst(input logic [3:0] c, input logic [19:0] a);
    src.step(c, 1'b1, a, a ^ 20'h0F0F0, 1'b0, 1'b0);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_call(input logic [19:0] s);
    inst(csd_pkg::CLS_CALL_SP, s);
    idle();
    chkb(fetchValid, 1'b1, "call fetch pulse");
    chk(fetchAddr, s + csd_pkg::WORD_STEP, "call fetch address");
    idle();
    chkb(fetchValid, 1'b0, "call fetch pulse ends");
  endtask

  task automatic t_nest(input logic gap);
    src.nestEnable = 1'b1;
    inst(csd_pkg::CLS_LPM_ENTRY, 20'h04400);
    if (gap)
      inst(csd_pkg::CLS_NOP, 20'h04402);
    inst(csd_pkg::CLS_RETURN, 20'h04404);
    src.step(csd_pkg::CLS_OTHER, 1'b0, 20'h12340, 20'h0, 1'b1, 1'b0);
    idle();
    chkb(saveValid, 1'b1, "nested save pulse");
    chk(savedReturn, gap ? 20'h12340 : 20'h12342, "saved return");
    chkb(returnSkipped, ~gap, "return skipped");
    src.nestEnable = 1'b0;
  endtask

  task automatic t_pc(input logic gap, input logic pause);
    inst(csd_pkg::CLS_XWB_REG_MEM, 20'h08000);
    if (pause)
      idle();
    if (gap)
      inst(csd_pkg::CLS_NOP, 20'h08004);
    src.step(csd_pkg::CLS_X_PC_INDIRECT, 1'b1, 20'h08006, 20'hABCD4, 1'b0, 1'b0);
    idle();
    chkb(pcCorrupt, ~gap, "pc corrupt flag");
    chkb(fetchValid, 1'b1, "pc write pulse");
    chk(fetchAddr, gap ? 20'hABCD4 : 20'hABCD4 ^ csd_pkg::PC_CORRUPT_XOR, "pc write");
  endtask

  // Only an indexed-source lpm entry arms; a plain entry must leave the width normal
  task automatic t_width(input logic gap, input logic idx);
    src.nmiPending = 1'b1;
    inst(idx ? csd_pkg::CLS_LPM_INDEXED : csd_pkg::CLS_LPM_ENTRY, 20'h0A000);
    if (gap)
      inst(csd_pkg::CLS_NOP, 20'h0A004);
    inst(csd_pkg::CLS_X20_REG_REG, 20'h0A006);
    src.step(csd_pkg::CLS_OTHER, 1'b0, 20'h0, 20'h0, 1'b0, 1'b1);
    idle();
    chk({18'h0, handlerWidth}, (gap || !idx) ? 20'h0 : {18'h0, csd_pkg::WIDTH_20}, "handler width");
    src.nmiPending = 1'b0;
  endtask

  // Mid-run reset must drop a pending width arming
  task automatic t_reset();
    src.nmiPending = 1'b1;
    inst(csd_pkg::CLS_LPM_INDEXED, 20'h0A000);
    inst(csd_pkg::CLS_X20_REG_REG, 20'h0A006);
    idle();
    sys_rst = 1'b1;
    idle();
    sys_rst = 1'b0;
    src.step(csd_pkg::CLS_OTHER, 1'b0, 20'h0, 20'h0, 1'b0, 1'b1);
    idle();
    chk({18'h0, handlerWidth}, 20'h0, "width after mid-run reset");
    src.nmiPending = 1'b0;
  endtask

  // ****************************************************************
  // Sequence, watchdog and verdict
  // ****************************************************************
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // About 60 cycles of work; the limit is generous on purpose
  initial
  begin
    #200000;
    fail_count++;
    complete_run();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk(fetchAddr, 20'h0, "reset fetch address");
    chk({18'h0, handlerWidth}, 20'h0, "reset width");
    t_call(20'h0FFF0);
    t_call(20'hFFFFE);
    t_nest(1'b0);
    t_nest(1'b1);
    t_pc(1'b0, 1'b0);
    t_pc(1'b0, 1'b1);
    t_pc(1'b1, 1'b0);
    t_width(1'b0, 1'b1);
    t_width(1'b0, 1'b0);
    t_width(1'b1, 1'b1);
    t_reset();
    complete_run();
  end
endmodule
